/* rtl/nand_feature_pkg.sv */
// constants for the serial nand status, drive and one-time area block
package nand_feature_pkg;
  // serial command opcodes
  localparam logic [7:0] OPC_WRITE_PERMIT = 8'h06;
  localparam logic [7:0] OPC_WRITE_FORBID = 8'h04;
  localparam logic [7:0] OPC_ARRAY_FETCH = 8'h13;
  localparam logic [7:0] OPC_ARRAY_COMMIT = 8'h10;
  localparam logic [7:0] OPC_SECTOR_WIPE = 8'hD8;
  localparam logic [7:0] OPC_SOFT_RESET = 8'hFF;
  localparam logic [7:0] OPC_FEATURE_FETCH = 8'h0F;
  localparam logic [7:0] OPC_FEATURE_STORE = 8'h1F;
  // feature addresses
  localparam logic [7:0] FA_PROTECT = 8'hA0;
  localparam logic [7:0] FA_CONFIG = 8'hB0;
  localparam logic [7:0] FA_STATUS = 8'hC0;
  localparam logic [7:0] FA_DRIVE = 8'hD0;
  localparam logic [7:0] FA_BLOCKSTAT = 8'hF0;
  // status byte fields
  localparam int ST_BUSY = 0;
  localparam int ST_WPERMIT = 1;
  localparam int ST_EFAIL = 2;
  localparam int ST_PFAIL = 3;
  localparam int ST_ECC_LO = 4;
  // configuration byte fields
  localparam int CFG_OTP_LOCK = 7;
  localparam int CFG_OTP_SEL = 6;
  localparam int CFG_ECC_EN = 4;
  // drive and block status fields
  localparam int DRV_LO = 5;
  localparam int BS_LOCKED = 3;
  localparam int BS_COUNT_LO = 4;
  // reset values and writable masks
  localparam logic [7:0] PROTECT_RST = 8'h38;
  localparam logic [7:0] PROTECT_MASK = 8'hBE;
  localparam logic [7:0] CONFIG_RST = 8'h10;
  localparam logic [7:0] CONFIG_MASK = 8'hD1;
  localparam logic [1:0] DRIVE_RST = 2'h0;
  localparam logic BLOCK_LOCKED_RST = 1'b1;
  // correction outcome codes
  localparam logic [1:0] ECC_NONE = 2'h0;
  localparam logic [1:0] ECC_FIXED = 2'h1;
  localparam logic [1:0] ECC_UNCORR = 2'h2;
  // one-time area holds pages 0 to 3
  localparam logic [23:0] OTP_LAST_PAGE = 24'h000003;
  // soft reset busy time
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_BUSY_NS = 5000;
  localparam int RESET_BUSY_CYCLES = (RESET_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {AOP_READ, AOP_PROG, AOP_ERASE, AOP_LOCK} array_op_e;
endpackage

/* rtl/nand_feature_ctrl.sv */
// status, drive and one-time area control with serial link front end
// Contract
// - program fail flag sets on failed program, bad address or protected target
// - program fail flag clears on each commit command taken while idle and on soft reset
// - erase fail flag sets on failed erase or erase of locked region
// - erase fail flag clears at start of wipe and on soft reset
// - commit and wipe are accepted only while write permit latch is set
// - permit command sets latch, forbid clears it, status shows it
// - busy flag high while commit, fetch, wipe or reset execute
// - two-bit pad drive level, default 00, soft reset keeps it
// - selected block locked flag, one at power-up, kept by soft reset
// - feature fetch of address C0 returns the status byte
// - feature address D0 stores and returns the drive level bits
// - correction outcome 00 none, 01 fixed with count, 10 uncorrected
// - one-time area has four pages, 00 to 03, while selected
// - fetch reads one-time pages while selected
// - select low means normal array, select high unlocked means one-time area
// - select plus lock store, permit, commit locks area permanently
// - lock set at power-on allows only reads of the one-time area
// - one-time area never erased, never reprogrammed once locked
// - correction coding applied to one-time programs when enabled
// - lock ships as zero and reads one after completed lock sequence
// - status byte: busy 0, permit 1, erase fail 2, program fail 3, outcome 5:4
// - lock and select bits live in configuration address B0
// - C0 and F0 read-only; A0, B0, D0 read and write
// - outcome and count clear on reset and read start, update on completion
`timescale 1ns/10ps
module nand_feature_ctrl
  import nand_feature_pkg::*;
#(
  parameter int ROW_W = 24
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_MOSI,
  output logic O_MISO,
  output logic O_MISO_OE,
  output logic O_ARRAY_START,
  output array_op_e O_ARRAY_OP,
  output logic [ROW_W-1:0] O_ARRAY_ROW,
  output logic O_ARRAY_OTP,
  output logic O_ECC_EN,
  output logic [1:0] O_PAD_DRIVE,
  output logic [7:0] O_PROTECT,
  output logic O_BUSY,
  input wire logic I_ARRAY_DONE,
  input wire logic I_ARRAY_FAIL,
  input wire logic [1:0] I_ECC_OUTCOME,
  input wire logic [1:0] I_ECC_COUNT,
  input wire logic I_SEL_BLOCK_PROT,
  input wire logic I_ADDR_INVALID,
  input wire logic I_OTP_LOCK_NV
);

  function automatic logic [7:0] feature_pick(input logic [39:0] img, input logic [7:0] fa);
    logic [7:0] v;
    v = 8'h00;
    unique case (fa)
      FA_PROTECT: v = img[39:32];
      FA_CONFIG: v = img[31:24];
      FA_STATUS: v = img[23:16];
      FA_DRIVE: v = img[15:8];
      FA_BLOCKSTAT: v = img[7:0];
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link side, serial clock domain

  // frame state ends with chip select, so no edge after the frame is needed
  logic link_rst_n;
  assign link_rst_n = I_NRST & ~I_CS_N;

  logic [5:0] bit_cnt;
  logic [6:0] shift_in;
  logic [7:0] cmd_l;
  logic [15:0] addr_l;
  logic [7:0] sh_next;
  logic byte_done;
  logic [2:0] byte_idx;
  assign sh_next = {shift_in, I_MOSI};
  assign byte_done = (bit_cnt[2:0] == 3'h7);
  assign byte_idx = bit_cnt[5:3];

  always_ff @(posedge I_SCLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt <= 6'h00;
      shift_in <= 7'h00;
    end else begin
      shift_in <= sh_next[6:0];
      if (bit_cnt != 6'h3F) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge I_SCLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cmd_l <= 8'h00;
      addr_l <= 16'h0000;
    end else if (byte_done) begin
      if (byte_idx == 3'h0) begin
        cmd_l <= sh_next;
      end else if (byte_idx == 3'h1) begin
        addr_l[15:8] <= sh_next;
      end else if (byte_idx == 3'h2) begin
        addr_l[7:0] <= sh_next;
      end
    end
  end

  // command hand-over: hold words change only with the request toggle
  logic deliver;
  logic req_tog;
  logic [7:0] cmd_h;
  logic [23:0] addr_h;
  logic [7:0] fdata_h;
  always_comb begin
    deliver = 1'b0;
    if (byte_done && byte_idx == 3'h0) begin
      deliver = (sh_next == OPC_WRITE_PERMIT) || (sh_next == OPC_WRITE_FORBID) ||
                (sh_next == OPC_SOFT_RESET);
    end else if (byte_done && byte_idx == 3'h2) begin
      deliver = (cmd_l == OPC_FEATURE_STORE);
    end else if (byte_done && byte_idx == 3'h3) begin
      deliver = (cmd_l == OPC_ARRAY_FETCH) || (cmd_l == OPC_ARRAY_COMMIT) ||
                (cmd_l == OPC_SECTOR_WIPE);
    end
  end

  always_ff @(posedge I_SCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      req_tog <= 1'b0;
      cmd_h <= 8'h00;
      addr_h <= 24'h000000;
      fdata_h <= 8'h00;
    end else if (deliver) begin
      req_tog <= ~req_tog;
      cmd_h <= (byte_idx == 3'h0) ? sh_next : cmd_l;
      addr_h <= {addr_l, sh_next};
      fdata_h <= sh_next;
    end
  end

  // feature image arrives by toggle handshake from the core domain
  logic [39:0] mirror;
  logic mir_tog;
  logic mir_s1;
  logic mir_s2;
  logic mir_seen;
  logic [39:0] mirror_l;
  always_ff @(posedge I_SCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      mir_s1 <= 1'b0;
      mir_s2 <= 1'b0;
      mir_seen <= 1'b0;
      mirror_l <= 40'h0000000000;
    end else begin
      mir_s1 <= mir_tog;
      mir_s2 <= mir_s1;
      if (mir_s2 != mir_seen) begin
        mir_seen <= mir_s2;
        mirror_l <= mirror;
      end
    end
  end

  logic [7:0] out_byte;
  logic out_en;
  always_ff @(posedge I_SCLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      out_byte <= 8'h00;
      out_en <= 1'b0;
    end else if (byte_done && byte_idx == 3'h1 && cmd_l == OPC_FEATURE_FETCH) begin
      out_byte <= feature_pick(mirror_l, sh_next);
      out_en <= 1'b1;
    end
  end

  // launch on falling edge so the host samples a settled bit
  always_ff @(negedge I_SCLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      O_MISO <= 1'b0;
      O_MISO_OE <= 1'b0;
    end else begin
      O_MISO <= out_byte[~bit_cnt[2:0]];
      O_MISO_OE <= out_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command reception, core clock domain

  logic req_s1;
  logic req_s2;
  logic req_seen;
  logic cmd_evt;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_seen <= 1'b0;
    end else begin
      req_s1 <= req_tog;
      req_s2 <= req_s1;
      req_seen <= req_s2;
    end
  end
  assign cmd_evt = req_s2 != req_seen;

  typedef enum logic [1:0] {CS_IDLE, CS_ARRAY, CS_RESET} core_state_e;
  core_state_e state;
  array_op_e op_kind;
  logic [7:0] protect;
  logic [7:0] config_w;
  logic [1:0] drive;
  logic wpermit;
  logic pfail;
  logic efail;
  logic [1:0] ecc_out;
  logic [1:0] ecc_cnt;
  logic blk_locked;
  logic otp_nv;
  logic otp_burned;
  logic strap_done;
  logic [$clog2(RESET_BUSY_CYCLES+1)-1:0] rst_cnt;

  logic go;
  logic otp_sel;
  logic otp_locked;
  logic is_commit;
  logic is_wipe;
  logic prog_try;
  logic lock_burn;
  logic prog_reject;
  logic prog_start;
  logic erase_try;
  logic erase_reject;
  logic erase_start;
  logic read_start;
  logic reset_cmd;
  logic store_cmd;
  logic array_end;

  assign go = cmd_evt && (state == CS_IDLE);
  assign otp_sel = config_w[CFG_OTP_SEL];
  assign otp_locked = otp_nv | otp_burned;
  assign is_commit = go && (cmd_h == OPC_ARRAY_COMMIT);
  assign is_wipe = go && (cmd_h == OPC_SECTOR_WIPE);
  assign prog_try = is_commit && wpermit;
  assign erase_try = is_wipe && wpermit;
  assign lock_burn = prog_try && otp_sel && config_w[CFG_OTP_LOCK] && !otp_locked;
  assign prog_reject = prog_try && !lock_burn &&
                       ((otp_sel && (otp_locked || addr_h > OTP_LAST_PAGE)) ||
                        (!otp_sel && I_SEL_BLOCK_PROT) || I_ADDR_INVALID);
  assign prog_start = prog_try && !lock_burn && !prog_reject;
  assign erase_reject = erase_try && (otp_sel || I_SEL_BLOCK_PROT || I_ADDR_INVALID);
  assign erase_start = erase_try && !erase_reject;
  assign read_start = go && (cmd_h == OPC_ARRAY_FETCH);
  assign reset_cmd = cmd_evt && (cmd_h == OPC_SOFT_RESET);
  assign store_cmd = cmd_evt && (cmd_h == OPC_FEATURE_STORE);
  assign array_end = (state == CS_ARRAY) && I_ARRAY_DONE;

  ////////////////////////////////////////////////////////////////////////////
  // operation sequencing

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state <= CS_IDLE;
      rst_cnt <= '0;
    end else if (reset_cmd) begin
      state <= CS_RESET;
      rst_cnt <= '0;
    end else begin
      unique case (state)
        CS_IDLE: begin
          if (prog_start || erase_start || read_start || lock_burn) begin
            state <= CS_ARRAY;
          end
        end
        CS_ARRAY: begin
          if (I_ARRAY_DONE) begin
            state <= CS_IDLE;
          end
        end
        CS_RESET: begin
          rst_cnt <= rst_cnt + 1'b1;
          if (rst_cnt == ($bits(rst_cnt))'(RESET_BUSY_CYCLES - 1)) begin
            state <= CS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_ARRAY_START <= 1'b0;
      O_ARRAY_OP <= AOP_READ;
      O_ARRAY_ROW <= '0;
      op_kind <= AOP_READ;
    end else begin
      O_ARRAY_START <= prog_start || erase_start || read_start || lock_burn;
      if (prog_start || erase_start || read_start || lock_burn) begin
        O_ARRAY_ROW <= addr_h[ROW_W-1:0];
        op_kind <= lock_burn ? AOP_LOCK : prog_start ? AOP_PROG :
                   erase_start ? AOP_ERASE : AOP_READ;
        O_ARRAY_OP <= lock_burn ? AOP_LOCK : prog_start ? AOP_PROG :
                      erase_start ? AOP_ERASE : AOP_READ;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags; a fail flag set in the clearing cycle wins, soft reset wins over an outcome update

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pfail <= 1'b0;
    end else begin
      if (is_commit || reset_cmd) begin
        pfail <= 1'b0;
      end
      if (prog_reject || (array_end && op_kind == AOP_PROG && I_ARRAY_FAIL)) begin
        pfail <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      efail <= 1'b0;
    end else begin
      if (is_wipe || reset_cmd) begin
        efail <= 1'b0;
      end
      if (erase_reject || (array_end && op_kind == AOP_ERASE && I_ARRAY_FAIL)) begin
        efail <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      wpermit <= 1'b0;
    end else if (reset_cmd || (go && cmd_h == OPC_WRITE_FORBID)) begin
      wpermit <= 1'b0;
    end else if (go && cmd_h == OPC_WRITE_PERMIT) begin
      wpermit <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ecc_out <= ECC_NONE;
      ecc_cnt <= 2'h0;
    end else if (reset_cmd || read_start) begin
      ecc_out <= ECC_NONE;
      ecc_cnt <= 2'h0;
    end else if (array_end && op_kind == AOP_READ && !I_ARRAY_FAIL) begin
      ecc_out <= I_ECC_OUTCOME;
      ecc_cnt <= (I_ECC_OUTCOME == ECC_FIXED) ? I_ECC_COUNT : 2'h0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      blk_locked <= BLOCK_LOCKED_RST;
    end else begin
      blk_locked <= I_SEL_BLOCK_PROT;
    end
  end

  // burned lock holds through soft reset and clears only on hardware reset; strap caught after release
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      otp_nv <= 1'b0;
      strap_done <= 1'b0;
      otp_burned <= 1'b0;
    end else begin
      if (!strap_done) begin
        otp_nv <= I_OTP_LOCK_NV;
        strap_done <= 1'b1;
      end
      if (lock_burn) begin
        otp_burned <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // feature registers

  // status and block status ignore stores
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      protect <= PROTECT_RST;
      config_w <= CONFIG_RST;
      drive <= DRIVE_RST;
    end else if (store_cmd) begin
      unique case (addr_h[23:16])
        FA_PROTECT: protect <= fdata_h & PROTECT_MASK;
        FA_CONFIG: config_w <= fdata_h & CONFIG_MASK;
        FA_DRIVE: drive <= fdata_h[DRV_LO+1:DRV_LO];
        default: drive <= drive;
      endcase
    end
  end

  logic [7:0] status;
  logic [7:0] cfg_rd;
  logic [39:0] live;
  always_comb begin
    status = 8'h00;
    status[ST_BUSY] = (state != CS_IDLE);
    status[ST_WPERMIT] = wpermit;
    status[ST_EFAIL] = efail;
    status[ST_PFAIL] = pfail;
    status[ST_ECC_LO+1 -: 2] = ecc_out;
    cfg_rd = config_w;
    cfg_rd[CFG_OTP_LOCK] = config_w[CFG_OTP_LOCK] | otp_locked;
    live = {protect, cfg_rd, status, 8'h00, 8'h00};
    live[8+DRV_LO+1 -: 2] = drive;
    live[BS_LOCKED] = blk_locked;
    live[BS_COUNT_LO+1 -: 2] = ecc_cnt;
  end

  // image refreshes only after the link side took the last one
  logic ack_s1;
  logic ack_s2;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      mir_tog <= 1'b0;
      mirror <= 40'h0000000000;
    end else begin
      ack_s1 <= mir_seen;
      ack_s2 <= ack_s1;
      if (ack_s2 == mir_tog && live != mirror) begin
        mirror <= live;
        mir_tog <= ~mir_tog;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_ARRAY_OTP <= 1'b0;
      O_ECC_EN <= CONFIG_RST[CFG_ECC_EN];
      O_PAD_DRIVE <= DRIVE_RST;
      O_PROTECT <= PROTECT_RST;
      O_BUSY <= 1'b0;
    end else begin
      O_ARRAY_OTP <= otp_sel;
      O_ECC_EN <= config_w[CFG_ECC_EN];
      O_PAD_DRIVE <= drive;
      O_PROTECT <= protect;
      O_BUSY <= (state != CS_IDLE);
    end
  end

endmodule // nand_feature_ctrl

/* dv/nand_feature_ctrl_properties.sv */
// concurrent checks on the feature controller core-side ports and the data output enable
`timescale 1ns/10ps
module nand_feature_ctrl_properties
  import nand_feature_pkg::*;
#(
  parameter int ROW_W = 24
) (
  input logic I_CLK,
  input logic I_NRST,
  input logic I_CS_N,
  input logic I_ARRAY_DONE,
  input logic O_MISO_OE,
  input logic O_ARRAY_START,
  input array_op_e O_ARRAY_OP,
  input logic [ROW_W-1:0] O_ARRAY_ROW,
  input logic O_ARRAY_OTP,
  input logic O_BUSY
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);
  ////////////////////////////////////////////////////////////////
  start_one_shot_a: assert property (O_ARRAY_START |=> !O_ARRAY_START)
    else $error("array start longer than one cycle");
  busy_after_start_a: assert property (O_ARRAY_START |=> O_BUSY)
    else $error("busy not raised after array start");
  done_ends_busy_a: assert property (O_BUSY && I_ARRAY_DONE |-> ##2 !O_BUSY)
    else $error("busy not dropped after array done");
  start_when_idle_a: assert property (O_ARRAY_START |-> !$past(O_BUSY))
    else $error("array start while busy");
  erase_spares_otp_a: assert property (O_ARRAY_START && O_ARRAY_OTP |-> O_ARRAY_OP != AOP_ERASE)
    else $error("erase aimed at one-time area");
  lock_needs_sel_a: assert property (O_ARRAY_START && O_ARRAY_OP == AOP_LOCK |-> O_ARRAY_OTP)
    else $error("lock burn without one-time select");
  otp_page_range_a: assert property (O_ARRAY_START && O_ARRAY_OTP |-> O_ARRAY_ROW <= OTP_LAST_PAGE)
    else $error("one-time page beyond last page");
  oe_released_a: assert property (I_CS_N [*4] |-> !O_MISO_OE)
    else $error("data output driven outside a frame");
  reset_busy_hold_a: assert property ($rose(O_BUSY) && !$past(O_ARRAY_START) |-> O_BUSY [*8])
    else $error("soft reset busy too short");
endmodule // nand_feature_ctrl_properties

bind nand_feature_ctrl nand_feature_ctrl_properties #(.ROW_W(ROW_W)) props_u (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_CS_N(I_CS_N), .I_ARRAY_DONE(I_ARRAY_DONE),
  .O_MISO_OE(O_MISO_OE), .O_ARRAY_START(O_ARRAY_START), .O_ARRAY_OP(O_ARRAY_OP),
  .O_ARRAY_ROW(O_ARRAY_ROW), .O_ARRAY_OTP(O_ARRAY_OTP), .O_BUSY(O_BUSY)
);

/* dv/nand_spi_host.sv */
// serial host model that frames commands into the feature controller
`timescale 1ns/10ps
module nand_spi_host
  import nand_feature_pkg::*;
(
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input logic i_miso
);
  logic [7:0] unused;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // msb first frames
  // link clock stands still between frames
  task automatic xfer(input logic [31:0] v, input int n, output logic [7:0] rx);
    rx = 8'h00;
    #7 o_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #16 o_mosi = v[31];
      v = v << 1;
      #16 o_sclk = 1'b1;
      if (i > 15) rx = {rx[6:0], i_miso};
      #32 o_sclk = 1'b0;
    end
    #32 o_cs_n = 1'b1;
    // released line must not echo the last bit
    o_mosi = ~o_mosi;
    // gap covers command spacing and mirror handshake
    #600;
  endtask
  task automatic cmd(input logic [7:0] op);
    xfer({op, 24'h0}, 8, unused);
  endtask
  task automatic cmd_row(input logic [7:0] op, input logic [23:0] row);
    xfer({op, row}, 32, unused);
  endtask
  task automatic store(input logic [7:0] a, input logic [7:0] d);
    xfer({OPC_FEATURE_STORE, a, d, 8'h0}, 24, unused);
  endtask
  task automatic fetch(input logic [7:0] a, output logic [7:0] d);
    xfer({OPC_FEATURE_FETCH, a, 16'h0}, 24, d);
  endtask
endmodule // nand_spi_host

/* dv/nand_feature_ctrl_tb_top.sv */
// self-checking bench for the feature controller
`timescale 1ns/10ps
module nand_feature_ctrl_tb_top
  import nand_feature_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe, start, otp, ecc_en, busy;
  array_op_e op;
  logic [23:0] row;
  logic [1:0] pad;
  logic [7:0] prot, rd;
  // array model powers up with every block protected
  logic done = 1'b0, fail = 1'b0, prot_blk = 1'b1, addr_bad = 1'b0, lock_nv = 1'b0;
  logic [1:0] ecc_out = 2'h0, ecc_cnt = 2'h0;
  logic fail_cfg = 1'b0;
  int err_total = 0, n_compared = 0, n_start = 0;
  always #50 clk = ~clk;
  nand_feature_ctrl dut_u (
    .I_CLK(clk), .I_NRST(nrst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_MOSI(mosi),
    .O_MISO(miso), .O_MISO_OE(miso_oe), .O_ARRAY_START(start), .O_ARRAY_OP(op),
    .O_ARRAY_ROW(row), .O_ARRAY_OTP(otp), .O_ECC_EN(ecc_en), .O_PAD_DRIVE(pad),
    .O_PROTECT(prot), .O_BUSY(busy), .I_ARRAY_DONE(done), .I_ARRAY_FAIL(fail),
    .I_ECC_OUTCOME(ecc_out), .I_ECC_COUNT(ecc_cnt), .I_SEL_BLOCK_PROT(prot_blk),
    .I_ADDR_INVALID(addr_bad), .I_OTP_LOCK_NV(lock_nv)
  );
  // released line shows the inverse, so a read outside the drive window fails
  logic miso_line;
  assign miso_line = miso_oe ? miso : ~miso;
  nand_spi_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso_line));
  // slow array answer so status fetches catch busy
  always @(posedge clk) begin
    if (start) begin
      n_start <= n_start + 1;
      repeat (40) @(posedge clk);
      done <= 1'b1;
      fail <= fail_cfg;
      @(posedge clk);
      done <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic fchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.fetch(a, rd);
    chk(rd, exp);
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 300) begin
      @(posedge clk);
      k++;
    end
    chk(8'(busy), 8'h00);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_reset_vals;
    fchk(FA_STATUS, 8'h00);
    fchk(FA_CONFIG, 8'h10);
    fchk(FA_DRIVE, 8'h00);
    fchk(FA_BLOCKSTAT, 8'h08);
    @(posedge clk) prot_blk <= 1'b0;
    fchk(FA_BLOCKSTAT, 8'h00);
    fchk(FA_PROTECT, 8'h38);
    host_u.store(FA_PROTECT, 8'h00);
    fchk(FA_PROTECT, 8'h00);
    chk(prot, 8'h00);
    host_u.cmd(OPC_WRITE_PERMIT);
    fchk(FA_STATUS, 8'h02);
    host_u.cmd(OPC_WRITE_FORBID);
    fchk(FA_STATUS, 8'h00);
    host_u.store(FA_STATUS, 8'hFF);
    fchk(FA_STATUS, 8'h00);
  endtask
  task automatic s_drive;
    for (int l = 0; l < 4; l++) begin
      host_u.store(FA_DRIVE, 8'(l << DRV_LO));
      fchk(FA_DRIVE, 8'(l << DRV_LO));
      chk({6'h0, pad}, 8'(l));
    end
  endtask
  task automatic s_program;
    fail_cfg = 1'b1;
    host_u.cmd(OPC_WRITE_PERMIT);
    host_u.cmd_row(OPC_ARRAY_COMMIT, 24'h000040);
    chk(row[7:0], 8'h40);
    chk({7'h0, otp}, 8'h00);
    chk(8'(op), 8'(AOP_PROG));
    wait_idle();
    fchk(FA_STATUS, 8'h0A);
    fail_cfg = 1'b0;
    host_u.cmd_row(OPC_ARRAY_COMMIT, 24'h000041);
    fchk(FA_STATUS, 8'h03);
    wait_idle();
    fchk(FA_STATUS, 8'h02);
    host_u.cmd(OPC_WRITE_FORBID);
    host_u.cmd_row(OPC_ARRAY_COMMIT, 24'h000042);
    chk(8'(n_start), 8'h02);
  endtask
  task automatic s_protect;
    @(posedge clk) addr_bad <= 1'b1;
    host_u.cmd(OPC_WRITE_PERMIT);
    host_u.cmd_row(OPC_ARRAY_COMMIT, 24'h000080);
    fchk(FA_STATUS, 8'h0A);
    @(posedge clk) addr_bad <= 1'b0;
    prot_blk <= 1'b1;
    host_u.cmd_row(OPC_SECTOR_WIPE, 24'h000080);
    fchk(FA_STATUS, 8'h0E);
    @(posedge clk) prot_blk <= 1'b0;
    host_u.cmd_row(OPC_SECTOR_WIPE, 24'h000080);
    wait_idle();
    fchk(FA_STATUS, 8'h0A);
  endtask
  task automatic s_read_ecc;
    logic [1:0] outc;
    for (int c = 0; c < 3; c++) begin
      outc = 2'((c + 1) % 3);
      @(posedge clk) ecc_out <= outc;
      ecc_cnt <= 2'h3;
      host_u.cmd_row(OPC_ARRAY_FETCH, 24'h000100);
      fchk(FA_STATUS, 8'h0B);
      wait_idle();
      fchk(FA_STATUS, {2'h0, outc, 4'hA});
      host_u.fetch(FA_BLOCKSTAT, rd);
      chk(rd & 8'h30, (outc == ECC_FIXED) ? 8'h30 : 8'h00);
    end
  endtask
  task automatic s_otp;
    host_u.store(FA_CONFIG, 8'h50);
    fchk(FA_CONFIG, 8'h50);
    chk({6'h0, otp, ecc_en}, 8'h03);
    for (int p = 0; p < 4; p++) begin
      host_u.cmd_row(OPC_ARRAY_COMMIT, 24'(p));
      wait_idle();
    end
    chk(8'(n_start), 8'h0A);
    host_u.cmd_row(OPC_ARRAY_FETCH, 24'h000003);
    chk(row[7:0], 8'h03);
    chk(8'(op), 8'(AOP_READ));
    wait_idle();
    host_u.cmd_row(OPC_ARRAY_COMMIT, 24'(OTP_LAST_PAGE + 24'h1));
    host_u.cmd_row(OPC_SECTOR_WIPE, 24'h000000);
    fchk(FA_STATUS, 8'h0E);
    host_u.store(FA_CONFIG, 8'hD0);
    host_u.cmd(OPC_WRITE_PERMIT);
    host_u.cmd_row(OPC_ARRAY_COMMIT, 24'h000000);
    wait_idle();
    host_u.store(FA_CONFIG, 8'h50);
    fchk(FA_CONFIG, 8'hD0);
    host_u.cmd_row(OPC_ARRAY_COMMIT, 24'h000000);
    chk(8'(n_start), 8'h0C);
  endtask
  task automatic s_soft_reset;
    host_u.cmd(OPC_SOFT_RESET);
    fchk(FA_STATUS, 8'h01);
    wait_idle();
    fchk(FA_STATUS, 8'h00);
    fchk(FA_DRIVE, 8'h60);
    fchk(FA_CONFIG, 8'hD0);
  endtask
  task automatic s_nv_lock;
    @(posedge clk) nrst <= 1'b0;
    lock_nv <= 1'b1;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    host_u.store(FA_CONFIG, 8'h50);
    fchk(FA_CONFIG, 8'hD0);
    host_u.cmd(OPC_WRITE_PERMIT);
    host_u.cmd_row(OPC_ARRAY_COMMIT, 24'h000000);
    fchk(FA_STATUS, 8'h0A);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    s_reset_vals();
    s_drive();
    s_program();
    s_protect();
    s_read_ecc();
    s_otp();
    s_soft_reset();
    s_nv_lock();
    end_sim();
  end
  // whole run needs well under a millisecond
  initial begin
    #2_000_000;
    err_total++;
    $display("MISMATCH t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
    end_sim();
  end
endmodule // nand_feature_ctrl_tb_top
